/* hdl/cpidu_defs.vh */
// Purpose: Constants for the configuration port index/data unit
// Assumes: 8-bit ISA-style I/O data, 16-bit I/O address
// Notes:   Offsets are configuration register indices
`ifndef CPIDU_DEFS_VH
`define CPIDU_DEFS_VH

// ----------------------------------------
// Keys and port addresses
// ----------------------------------------
`define CPIDU_KEY_ENTER      8'h55
`define CPIDU_KEY_EXIT       8'haa
`define CPIDU_PORT_LO_STRAP0 8'hf0
`define CPIDU_PORT_LO_STRAP1 8'h70
`define CPIDU_PORT_HI_RST    8'h03
`define CPIDU_DATA_STEP      16'h0001

// ----------------------------------------
// Global register indices
// ----------------------------------------
`define CPIDU_IDX_CONFIG_CONTROL   8'h02
`define CPIDU_IDX_INDEX_ADDRESS    8'h03
`define CPIDU_IDX_LDEV_SELECT      8'h07
`define CPIDU_IDX_DEV_ID           8'h20
`define CPIDU_IDX_DEV_REV          8'h21
`define CPIDU_IDX_POWER_CONTROL    8'h22
`define CPIDU_IDX_POWER_MGMT       8'h23
`define CPIDU_IDX_OSC_CONTROL      8'h24
`define CPIDU_IDX_PORT_BASE_LOW    8'h26
`define CPIDU_IDX_PORT_BASE_HIGH   8'h27
`define CPIDU_IDX_TEST_FOUR        8'h2b
`define CPIDU_IDX_TEST_FIVE        8'h2c
`define CPIDU_IDX_TEST_ONE         8'h2d
`define CPIDU_IDX_TEST_TWO         8'h2e
`define CPIDU_IDX_TEST_THREE       8'h2f

// ----------------------------------------
// Floppy logical device indices
// ----------------------------------------
`define CPIDU_LDEV_FLOPPY          8'h00
`define CPIDU_IDX_FLP_ACTIVATE     8'h30
`define CPIDU_IDX_FLP_BASE_HIGH    8'h60
`define CPIDU_IDX_FLP_BASE_LOW     8'h61
`define CPIDU_IDX_FLP_IRQ          8'h70
`define CPIDU_IDX_FLP_DMA          8'h74
`define CPIDU_IDX_FLP_MODE         8'hf0
`define CPIDU_IDX_FLP_OPTION       8'hf1
`define CPIDU_IDX_FLP_TYPE         8'hf2
`define CPIDU_IDX_FLP_DRIVE0       8'hf4
`define CPIDU_IDX_FLP_DRIVE1       8'hf5

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define CPIDU_RST_INDEX_ADDRESS 8'h03
`define CPIDU_RST_OSC           8'h04
`define CPIDU_RST_ZERO          8'h00
`define CPIDU_RST_FLP_BASE_HIGH 8'h03
`define CPIDU_RST_FLP_BASE_LOW  8'hf0
`define CPIDU_RST_FLP_IRQ       8'h06
`define CPIDU_RST_FLP_DMA       8'h02
`define CPIDU_RST_FLP_MODE      8'h0e
`define CPIDU_RST_FLP_TYPE      8'hff
`define CPIDU_SOFT_RESET_BIT    0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CPIDU_CLK_PERIOD_NS     50
`define CPIDU_BLOCK_TIME_US     500
`define CPIDU_BLOCK_CYCLES      ((`CPIDU_BLOCK_TIME_US * 1000) / `CPIDU_CLK_PERIOD_NS)

`endif

/* hdl/cpidu_top.v */
// Purpose: Configuration port, index/data access and global plus floppy registers
// Assumes: One-cycle io_wr_i/io_rd_i strobes synchronous to sys_clk_i
// Notes:   Read data is registered; valid one cycle after the read strobe
//
// How it works
// - Hard reset or main power-on reset leaves run state, all devices disabled.
// - Index and data ports act only in configuration state.
// - Strap is sampled at hard reset release or main power-on reset.
// - Strap low decodes the port at 0x03f0, high at 0x0370.
// - Port base comes from the two base registers, software may relocate it.
// - Every address decode is qualified by AEN; DMA cycles are ignored.
// - Writing 0x55 to the configuration port enters configuration state.
// - Writing 0xaa to the configuration port returns to run state.
// - Index port sits at the base, data port at base plus one.
// - Index 0x07 selects a logical device; later accesses route to it.
// - Global indices decode regardless of the selected logical device.
// - Only run and configuration states; run accepts the enter key once the power-on hold-off ends.
// - Writing one to bit 0 of index 0x02 soft-resets 0x07, 0x22 and floppy 0x30, 0x60, 0x61, 0x70, 0x74.
// - All host accesses are ignored for 500 us after main power-on reset.
// - Each register loads its value per reset type, else keeps contents.
// - Port base loads 0xf0/0x70 and 0x03 on hard or main reset only.
// - Identification and revision at 0x20 and 0x21 are hard wired.
// - Floppy base registers 0x60/0x61 reset to 0x03/0xf0 on every reset.
`include "cpidu_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module cpidu_top #(
  parameter [7:0]  DEV_ID       = 8'h5a,   // Arbitrary value
  parameter [7:0]  DEV_REV      = 8'h01,   // Arbitrary value
  parameter [31:0] BLOCK_CYCLES = `CPIDU_BLOCK_CYCLES
) (
  // Clock and resets
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  input  wire        main_por_i,
  input  wire        standby_por_i,
  // Board strap
  input  wire        addr_strap_i,
  // Host I/O bus
  input  wire [15:0] io_addr_i,
  input  wire [7:0]  io_wdata_i,
  input  wire        io_wr_i,
  input  wire        io_rd_i,
  input  wire        aen_i,
  output reg  [7:0]  io_rdata_o,
  output reg         io_rdata_oe_o,
  // Status and floppy configuration
  output reg         config_mode_o,
  output reg         floppy_active_o,
  output reg  [15:0] floppy_base_o
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_RUN    = 1'b0;
  localparam ST_CONFIG = 1'b1;

  // Index to one-hot-free lookup used by the floppy write path
  function is_floppy_idx;
    input [7:0] idx;
    begin
      case (idx)
        `CPIDU_IDX_FLP_ACTIVATE, `CPIDU_IDX_FLP_BASE_HIGH, `CPIDU_IDX_FLP_BASE_LOW,
        `CPIDU_IDX_FLP_IRQ, `CPIDU_IDX_FLP_DMA, `CPIDU_IDX_FLP_MODE,
        `CPIDU_IDX_FLP_OPTION, `CPIDU_IDX_FLP_TYPE, `CPIDU_IDX_FLP_DRIVE0,
        `CPIDU_IDX_FLP_DRIVE1: is_floppy_idx = 1'b1;
        default: is_floppy_idx = 1'b0;
      endcase
    end
  endfunction

  reg        state;
  // No strap copy is kept: the base registers take the pin on their load edge
  reg        strap_pend;
  reg [31:0] block_cnt;
  reg [7:0]  index_reg;
  reg [7:0]  index_address;
  reg [7:0]  ldev_select;
  reg [7:0]  power_control;
  reg [7:0]  power_mgmt;
  reg [7:0]  osc_control;
  reg [7:0]  port_base_low;
  reg [7:0]  port_base_high;
  reg [7:0]  test_four;
  reg [7:0]  test_five;
  reg [7:0]  test_one;
  reg [7:0]  test_two;
  reg [7:0]  test_three;
  reg [7:0]  flp_activate;
  reg [7:0]  flp_base_high;
  reg [7:0]  flp_base_low;
  reg [7:0]  flp_irq;
  reg [7:0]  flp_dma;
  reg [7:0]  flp_mode;
  reg [7:0]  flp_option;
  reg [7:0]  flp_type;
  reg [7:0]  flp_drive0;
  reg [7:0]  flp_drive1;
  reg [7:0]  next_rdata;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire [15:0] port_base = {port_base_high, port_base_low};
  wire        bus_open  = (block_cnt == 32'h0000_0000) & ~main_por_i;
  wire        hit_cfg   = bus_open & ~aen_i & (io_addr_i == port_base);
  wire        hit_data  = bus_open & ~aen_i & (io_addr_i == port_base + `CPIDU_DATA_STEP);
  wire        in_cfg    = (state == ST_CONFIG);
  wire        wr_index  = io_wr_i & hit_cfg & in_cfg;
  wire        wr_data   = io_wr_i & hit_data & in_cfg;
  wire        rd_index  = io_rd_i & hit_cfg & in_cfg;
  wire        rd_data   = io_rd_i & hit_data & in_cfg;
  // Floppy registers only answer when device zero is selected
  wire        flp_sel   = (ldev_select == `CPIDU_LDEV_FLOPPY);
  wire        flp_wr    = wr_data & flp_sel & is_floppy_idx(index_reg);
  wire        soft_rst  = wr_data & (index_reg == `CPIDU_IDX_CONFIG_CONTROL) &
                          io_wdata_i[`CPIDU_SOFT_RESET_BIT];
  wire        hard_rst  = sys_rst_i | main_por_i;

  // ----------------------------------------
  // Power-on access blanking
  // ----------------------------------------
  // Counter reloads while main power-on reset is held, so blanking starts at its release
  // Hard reset leaves it alone: the pin is often held across power-on release,
  // and clearing the count there would cut the hold-off short
  always @(posedge sys_clk_i) begin
    if (main_por_i) begin
      block_cnt <= BLOCK_CYCLES;
    end else if (block_cnt != 32'h0000_0000) begin
      block_cnt <= block_cnt - 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Pin cannot load under async reset, so capture on the first clock after release
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_pend <= 1'b1;
    end else begin
      strap_pend <= 1'b0;
    end
  end

  // ----------------------------------------
  // Run / configuration state
  // ----------------------------------------
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_RUN;
    end else if (main_por_i) begin
      state <= ST_RUN;
    end else if (io_wr_i & hit_cfg) begin
      case (state)
        ST_RUN: begin
          if (io_wdata_i == `CPIDU_KEY_ENTER) begin
            state <= ST_CONFIG;
          end
        end
        ST_CONFIG: begin
          if (io_wdata_i == `CPIDU_KEY_EXIT) begin
            state <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // Index register
  // ----------------------------------------
  // The exit key also lands here; harmless since the index is not used in run state
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      index_reg <= 8'h00;
    end else if (wr_index) begin
      index_reg <= io_wdata_i;
    end
  end

  // ----------------------------------------
  // Port base registers
  // ----------------------------------------
  // Strap pin is sampled here on the first clock after hard reset release,
  // or while main power-on reset is held; later relocation overrides it
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_base_low  <= `CPIDU_PORT_LO_STRAP0;
      port_base_high <= `CPIDU_PORT_HI_RST;
    end else if (main_por_i | strap_pend) begin
      port_base_low  <= addr_strap_i ? `CPIDU_PORT_LO_STRAP1 : `CPIDU_PORT_LO_STRAP0;
      port_base_high <= `CPIDU_PORT_HI_RST;
    end else if (wr_data & (index_reg == `CPIDU_IDX_PORT_BASE_LOW)) begin
      port_base_low  <= io_wdata_i;
    end else if (wr_data & (index_reg == `CPIDU_IDX_PORT_BASE_HIGH)) begin
      port_base_high <= io_wdata_i;
    end
  end

  // ----------------------------------------
  // Global registers
  // ----------------------------------------
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      index_address <= `CPIDU_RST_INDEX_ADDRESS;
      ldev_select   <= `CPIDU_RST_ZERO;
      power_control <= `CPIDU_RST_ZERO;
      power_mgmt    <= `CPIDU_RST_ZERO;
      osc_control   <= `CPIDU_RST_OSC;
    end else if (main_por_i | standby_por_i) begin
      index_address <= `CPIDU_RST_INDEX_ADDRESS;
      ldev_select   <= `CPIDU_RST_ZERO;
      power_control <= `CPIDU_RST_ZERO;
      power_mgmt    <= `CPIDU_RST_ZERO;
      osc_control   <= `CPIDU_RST_OSC;
    end else if (soft_rst) begin
      ldev_select   <= `CPIDU_RST_ZERO;
      power_control <= `CPIDU_RST_ZERO;
    end else if (wr_data) begin
      case (index_reg)
        `CPIDU_IDX_INDEX_ADDRESS: index_address <= io_wdata_i;
        `CPIDU_IDX_LDEV_SELECT:   ldev_select   <= io_wdata_i;
        `CPIDU_IDX_POWER_CONTROL: power_control <= io_wdata_i;
        `CPIDU_IDX_POWER_MGMT:    power_mgmt    <= io_wdata_i;
        `CPIDU_IDX_OSC_CONTROL:   osc_control   <= io_wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Test registers
  // ----------------------------------------
  // No value on hard reset: only power-on resets touch them
  always @(posedge sys_clk_i) begin
    if (main_por_i | standby_por_i) begin
      test_four  <= `CPIDU_RST_ZERO;
      test_five  <= `CPIDU_RST_ZERO;
      test_one   <= `CPIDU_RST_ZERO;
      test_two   <= `CPIDU_RST_ZERO;
      test_three <= `CPIDU_RST_ZERO;
    end else if (wr_data & ~sys_rst_i) begin
      case (index_reg)
        `CPIDU_IDX_TEST_FOUR:  test_four  <= io_wdata_i;
        `CPIDU_IDX_TEST_FIVE:  test_five  <= io_wdata_i;
        `CPIDU_IDX_TEST_ONE:   test_one   <= io_wdata_i;
        `CPIDU_IDX_TEST_TWO:   test_two   <= io_wdata_i;
        `CPIDU_IDX_TEST_THREE: test_three <= io_wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Floppy logical device registers
  // ----------------------------------------
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flp_activate  <= `CPIDU_RST_ZERO;
      flp_base_high <= `CPIDU_RST_FLP_BASE_HIGH;
      flp_base_low  <= `CPIDU_RST_FLP_BASE_LOW;
      flp_irq       <= `CPIDU_RST_FLP_IRQ;
      flp_dma       <= `CPIDU_RST_FLP_DMA;
      flp_mode      <= `CPIDU_RST_FLP_MODE;
      flp_option    <= `CPIDU_RST_ZERO;
      flp_type      <= `CPIDU_RST_FLP_TYPE;
      flp_drive0    <= `CPIDU_RST_ZERO;
      flp_drive1    <= `CPIDU_RST_ZERO;
    end else if (main_por_i | standby_por_i) begin
      flp_activate  <= `CPIDU_RST_ZERO;
      flp_base_high <= `CPIDU_RST_FLP_BASE_HIGH;
      flp_base_low  <= `CPIDU_RST_FLP_BASE_LOW;
      flp_irq       <= `CPIDU_RST_FLP_IRQ;
      flp_dma       <= `CPIDU_RST_FLP_DMA;
      flp_mode      <= `CPIDU_RST_FLP_MODE;
      flp_option    <= `CPIDU_RST_ZERO;
      flp_type      <= `CPIDU_RST_FLP_TYPE;
      flp_drive0    <= `CPIDU_RST_ZERO;
      flp_drive1    <= `CPIDU_RST_ZERO;
    end else if (soft_rst) begin
      flp_activate  <= `CPIDU_RST_ZERO;
      flp_base_high <= `CPIDU_RST_FLP_BASE_HIGH;
      flp_base_low  <= `CPIDU_RST_FLP_BASE_LOW;
      flp_irq       <= `CPIDU_RST_FLP_IRQ;
      flp_dma       <= `CPIDU_RST_FLP_DMA;
    end else if (flp_wr) begin
      case (index_reg)
        `CPIDU_IDX_FLP_ACTIVATE:  flp_activate  <= io_wdata_i;
        `CPIDU_IDX_FLP_BASE_HIGH: flp_base_high <= io_wdata_i;
        `CPIDU_IDX_FLP_BASE_LOW:  flp_base_low  <= io_wdata_i;
        `CPIDU_IDX_FLP_IRQ:       flp_irq       <= io_wdata_i;
        `CPIDU_IDX_FLP_DMA:       flp_dma       <= io_wdata_i;
        `CPIDU_IDX_FLP_MODE:      flp_mode      <= io_wdata_i;
        `CPIDU_IDX_FLP_OPTION:    flp_option    <= io_wdata_i;
        `CPIDU_IDX_FLP_TYPE:      flp_type      <= io_wdata_i;
        `CPIDU_IDX_FLP_DRIVE0:    flp_drive0    <= io_wdata_i;
        `CPIDU_IDX_FLP_DRIVE1:    flp_drive1    <= io_wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Control register is write only and reads back as zero
  always @* begin
    next_rdata = 8'h00;
    if (rd_index) begin
      next_rdata = index_reg;
    end else if (rd_data) begin
      case (index_reg)
        `CPIDU_IDX_INDEX_ADDRESS:  next_rdata = index_address;
        `CPIDU_IDX_LDEV_SELECT:    next_rdata = ldev_select;
        `CPIDU_IDX_DEV_ID:         next_rdata = DEV_ID;
        `CPIDU_IDX_DEV_REV:        next_rdata = DEV_REV;
        `CPIDU_IDX_POWER_CONTROL:  next_rdata = power_control;
        `CPIDU_IDX_POWER_MGMT:     next_rdata = power_mgmt;
        `CPIDU_IDX_OSC_CONTROL:    next_rdata = osc_control;
        `CPIDU_IDX_PORT_BASE_LOW:  next_rdata = port_base_low;
        `CPIDU_IDX_PORT_BASE_HIGH: next_rdata = port_base_high;
        `CPIDU_IDX_TEST_FOUR:      next_rdata = test_four;
        `CPIDU_IDX_TEST_FIVE:      next_rdata = test_five;
        `CPIDU_IDX_TEST_ONE:       next_rdata = test_one;
        `CPIDU_IDX_TEST_TWO:       next_rdata = test_two;
        `CPIDU_IDX_TEST_THREE:     next_rdata = test_three;
        `CPIDU_IDX_FLP_ACTIVATE:   next_rdata = flp_sel ? flp_activate  : 8'h00;
        `CPIDU_IDX_FLP_BASE_HIGH:  next_rdata = flp_sel ? flp_base_high : 8'h00;
        `CPIDU_IDX_FLP_BASE_LOW:   next_rdata = flp_sel ? flp_base_low  : 8'h00;
        `CPIDU_IDX_FLP_IRQ:        next_rdata = flp_sel ? flp_irq       : 8'h00;
        `CPIDU_IDX_FLP_DMA:        next_rdata = flp_sel ? flp_dma       : 8'h00;
        `CPIDU_IDX_FLP_MODE:       next_rdata = flp_sel ? flp_mode      : 8'h00;
        `CPIDU_IDX_FLP_OPTION:     next_rdata = flp_sel ? flp_option    : 8'h00;
        `CPIDU_IDX_FLP_TYPE:       next_rdata = flp_sel ? flp_type      : 8'h00;
        `CPIDU_IDX_FLP_DRIVE0:     next_rdata = flp_sel ? flp_drive0    : 8'h00;
        `CPIDU_IDX_FLP_DRIVE1:     next_rdata = flp_sel ? flp_drive1    : 8'h00;
        default:                   next_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_rdata_o      <= 8'h00;
      io_rdata_oe_o   <= 1'b0;
      config_mode_o   <= 1'b0;
      floppy_active_o <= 1'b0;
      floppy_base_o   <= 16'h0000;
    end else begin
      io_rdata_o      <= next_rdata;
      io_rdata_oe_o   <= rd_index | rd_data;
      config_mode_o   <= (state == ST_CONFIG) & ~hard_rst;
      floppy_active_o <= flp_activate[0];
      floppy_base_o   <= {flp_base_high, flp_base_low};
    end
  end

endmodule // cpidu_top

`default_nettype wire

/* sim/cpidu_host.sv */
// Purpose: Host processor model on the ISA-style I/O bus
// Assumes: One transfer at a time, strobe held for exactly one edge
// Notes:   Released address and data lines show the inverse of the last value driven; strobes and AEN return low
`timescale 1ns/10ps
`default_nettype none
module cpidu_host (
  // Clock and read return
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rdata_oe_i,
  // Bus drive
  output var logic [15:0] addr_o,
  output var logic [7:0]  wdata_o,
  output var logic        wr_o,
  output var logic        rd_o,
  output var logic        aen_o
);
  // Idle bus from time zero
  initial begin
    {addr_o, wdata_o, wr_o, rd_o, aen_o} = '0;
  end
  // One strobe; dma raises AEN so the unit must ignore the cycle
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic w, input logic dma,
                       output logic [7:0] q, output logic v);
    @(posedge clk_i);
    #1;
    {addr_o, wdata_o, wr_o, rd_o, aen_o} = {a, d, w, ~w, dma};
    @(posedge clk_i);
    #1;
    q = rdata_i;
    v = rdata_oe_i;
    // Floating lines must not look like a held value
    {addr_o, wdata_o, wr_o, rd_o, aen_o} = {~a, ~d, 3'h0};
  endtask
endmodule // cpidu_host
`default_nettype wire

/* sim/cpidu_chk_sva.sv */
// Purpose: Port-level assertions for the configuration port unit
// Assumes: Sees only the ports of cpidu_top
// Notes:   Helper counters mirror the power-on hold-off and reset settling
`timescale 1ns/10ps
`default_nettype none
module cpidu_chk #(parameter [31:0] BLOCK_CYCLES = 10000) (
  // Clock and resets
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        main_por_i,
  input wire logic        standby_por_i,
  // Host bus
  input wire logic [7:0]  io_wdata_i,
  input wire logic        io_wr_i,
  input wire logic        io_rd_i,
  input wire logic        aen_i,
  input wire logic        io_rdata_oe_o,
  // Status
  input wire logic        config_mode_o,
  input wire logic        floppy_active_o,
  input wire logic [15:0] floppy_base_o
);
  reg  [31:0] blank_cnt;
  reg  [1:0]  settle;
  wire        por_any = main_por_i | standby_por_i;
  // Outputs may still move just after any reset, so settle masks that
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      settle <= 2'h3;
    end else begin
      settle <= por_any ? 2'h3 : settle - {1'b0, settle != 2'h0};
    end
  end
  // Hold-off mirror ignores hard reset, as the unit does
  always @(posedge sys_clk_i) begin
    blank_cnt <= main_por_i ? BLOCK_CYCLES : blank_cnt - {31'h0, blank_cnt != 32'h0};
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Port behaviour
  a_aen_refused: assert property ((aen_i && settle == 2'h0 && !por_any) |=>
    !io_rdata_oe_o ##1 $stable(config_mode_o)) else $error("DMA cycle was decoded");
  a_run_no_read: assert property ((!config_mode_o && io_rd_i) |=> !io_rdata_oe_o)
    else $error("read answered in run state");
  a_enter_key: assert property ($rose(config_mode_o) |-> $past(io_wr_i, 2) && !$past(aen_i, 2)
    && $past(io_wdata_i, 2) == 8'h55) else $error("config state entered without key");
  a_exit_cause: assert property ($fell(config_mode_o) |-> $past(main_por_i) || $past(standby_por_i)
    || ($past(io_wr_i, 2) && $past(io_wdata_i, 2) == 8'haa)) else $error("config state left without key");
  a_quiet_hold: assert property ((settle == 2'h0 && !io_wr_i && !$past(io_wr_i) && !por_any) |=>
    $stable(config_mode_o)
    && $stable(floppy_active_o) && $stable(floppy_base_o)) else $error("state moved without a write");
  a_por_state: assert property (main_por_i |-> ##2 (!config_mode_o && !floppy_active_o))
    else $error("power-on reset left config or device active");
  a_standby_flp: assert property (standby_por_i |-> ##2 (floppy_base_o == 16'h03f0 && !floppy_active_o))
    else $error("standby reset missed floppy defaults");
  a_blank_hold: assert property ((blank_cnt > 32'h1) |=> !io_rdata_oe_o && $stable(config_mode_o))
    else $error("access taken during power-on hold-off");
endmodule // cpidu_chk
bind cpidu_top cpidu_chk #(.BLOCK_CYCLES(BLOCK_CYCLES)) i_chk (.sys_clk_i, .sys_rst_i, .main_por_i,
  .standby_por_i, .io_wdata_i, .io_wr_i, .io_rd_i, .aen_i, .io_rdata_oe_o, .config_mode_o,
  .floppy_active_o, .floppy_base_o);
`default_nettype wire

/* sim/tb_config_port_index_data_unit.sv */
// Purpose: Self-checking bench for the configuration port unit
// Assumes: Host model drives strobes 1 ns after the rising edge
// Notes:   Power-on hold-off shortened to 20 cycles
`timescale 1ns/10ps
`default_nettype none
module tb_config_port_index_data_unit;
  localparam [7:0] ID  = 8'h5a;  // Arbitrary value
  localparam [7:0] REV = 8'h01;  // Arbitrary value
  logic        clk, rst, mpor, spor, strap, wr, rd, aen, oe, mode, act;
  logic [15:0] addr, fbase;
  logic [7:0]  wdata, rdata;
  int          n_mismatch = 0;
  int          num_checks = 0;
  logic [7:0]  g_idx [10] = '{8'h03, 8'h07, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'h2d};
  logic [7:0]  g_rst [10] = '{8'h03, 8'h00, ID, REV, 8'h00, 8'h00, 8'h04, 8'hf0, 8'h03, 8'h00};
  logic [7:0]  f_idx [10] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hf0, 8'hf1, 8'hf2, 8'hf4, 8'hf5};
  logic [7:0]  f_rst [10] = '{8'h00, 8'h03, 8'hf0, 8'h06, 8'h02, 8'h0e, 8'h00, 8'hff, 8'h00, 8'h00};

  cpidu_top #(.DEV_ID(ID), .DEV_REV(REV), .BLOCK_CYCLES(20)) i_dut (.sys_clk_i(clk), .sys_rst_i(rst),
    .main_por_i(mpor), .standby_por_i(spor), .addr_strap_i(strap), .io_addr_i(addr), .io_wdata_i(wdata),
    .io_wr_i(wr), .io_rd_i(rd), .aen_i(aen), .io_rdata_o(rdata), .io_rdata_oe_o(oe),
    .config_mode_o(mode), .floppy_active_o(act), .floppy_base_o(fbase));
  cpidu_host i_host (.clk_i(clk), .rdata_i(rdata), .rdata_oe_i(oe), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .aen_o(aen));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Comparisons
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0, got}, {15'h0, exp});
  endtask
  // Port and register access; the aen flag makes a DMA cycle
  task automatic io(input logic [15:0] a, input logic [7:0] d, input logic w, input logic dma,
                    input logic v_exp, input logic [7:0] exp);
    logic [7:0] q;
    logic       v;
    i_host.cycle(a, d, w, dma, q, v);
    // Status outputs lag the taken strobe by one edge
    @(posedge clk);
    #1;
    if (!w) chk_bit(v, v_exp);
    if (!w) chk_val({8'h00, q}, {8'h00, exp});
  endtask
  task automatic reg_wr(input logic [15:0] b, input logic [7:0] i, input logic [7:0] d);
    io(b, i, 1'b1, 1'b0, 1'b0, 8'h00);
    io(b + 16'h0001, d, 1'b1, 1'b0, 1'b0, 8'h00);
  endtask
  task automatic reg_rd(input logic [15:0] b, input logic [7:0] i, input logic [7:0] exp);
    io(b, i, 1'b1, 1'b0, 1'b0, 8'h00);
    io(b + 16'h0001, 8'h00, 1'b0, 1'b0, 1'b1, exp);
  endtask

  // Hold-off, run-state refusals, DMA cycle, then entry
  task automatic t_run;
    io(16'h03f0, 8'h55, 1'b1, 1'b0, 1'b0, 8'h00);
    repeat (25) @(posedge clk);
    #1 chk_bit(mode, 1'b0);
    io(16'h03f0, 8'h07, 1'b1, 1'b0, 1'b0, 8'h00);
    io(16'h03f1, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_bit(mode, 1'b0);
    io(16'h03f0, 8'h55, 1'b1, 1'b1, 1'b0, 8'h00);
    chk_bit(mode, 1'b0);
    io(16'h03f0, 8'h55, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_bit(mode, 1'b1);
  endtask
  // Reset values, read-only identity, floppy routing and soft reset
  task automatic t_regs;
    foreach (g_idx[k]) reg_rd(16'h03f0, g_idx[k], g_rst[k]);
    reg_wr(16'h03f0, 8'h20, 8'h00);
    reg_rd(16'h03f0, 8'h20, ID);
    reg_wr(16'h03f0, 8'h07, 8'h00);
    foreach (f_idx[k]) reg_rd(16'h03f0, f_idx[k], f_rst[k]);
    reg_wr(16'h03f0, 8'h30, 8'h01);
    chk_bit(act, 1'b1);
    reg_wr(16'h03f0, 8'h60, 8'h02);
    reg_wr(16'h03f0, 8'h61, 8'h78);
    chk_val(fbase, 16'h0278);
    reg_wr(16'h03f0, 8'h24, 8'h15);
    reg_wr(16'h03f0, 8'h07, 8'h01);
    reg_rd(16'h03f0, 8'h60, 8'h00);
    reg_rd(16'h03f0, 8'h24, 8'h15);
    reg_wr(16'h03f0, 8'h02, 8'h01);
    chk_val(fbase, 16'h03f0);
    chk_bit(act, 1'b0);
    reg_rd(16'h03f0, 8'h07, 8'h00);
    reg_rd(16'h03f0, 8'h24, 8'h15);
  endtask
  // Relocation, exit, strap-selected base after hard reset, standby reset
  task automatic t_base;
    reg_wr(16'h03f0, 8'h30, 8'h01);
    reg_wr(16'h03f0, 8'h2d, 8'h5c);
    reg_wr(16'h03f0, 8'h26, 8'h80);
    io(16'h03f0, 8'haa, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_bit(mode, 1'b1);
    io(16'h0380, 8'haa, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_bit(mode, 1'b0);
    {rst, strap} = 2'b11;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    #1 strap = 1'b0;
    chk_bit(act, 1'b0);
    io(16'h03f0, 8'h55, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_bit(mode, 1'b0);
    io(16'h0370, 8'h55, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_bit(mode, 1'b1);
    reg_rd(16'h0370, 8'h26, 8'h70);
    reg_rd(16'h0370, 8'h2d, 8'h5c);
    reg_wr(16'h0370, 8'h30, 8'h01);
    @(posedge clk);
    #1 spor = 1'b1;
    @(posedge clk);
    #1 spor = 1'b0;
    io(16'h0370, 8'h55, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_bit(act, 1'b0);
    reg_rd(16'h0370, 8'h2d, 8'h00);
    reg_rd(16'h0370, 8'h26, 8'h70);
    // Main power-on reset in configuration state with the floppy active
    reg_wr(16'h0370, 8'h30, 8'h01);
    mpor = 1'b1;
    repeat (2) @(posedge clk);
    #1 mpor = 1'b0;
    chk_bit(mode, 1'b0);
    chk_bit(act, 1'b0);
    io(16'h03f0, 8'h55, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_bit(mode, 1'b0);
  endtask

  // Main sequence
  initial begin
    {rst, mpor, spor, strap} = 4'b1100;
    repeat (20) @(posedge clk);
    #1 {rst, mpor} = 2'b00;
    t_run;
    t_regs;
    t_base;
    print_verdict;
  end
  // Watchdog
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end
endmodule // tb_config_port_index_data_unit
`default_nettype wire
